// File: hdl/phase_seq_map.vh
`ifndef PHASE_SEQ_MAP_VH
`define PHASE_SEQ_MAP_VH
// AXI4-Lite register byte offsets
`define REG_CTRL        4'h0
`define REG_MICRO       4'h4
`define REG_STATUS      4'h8
`define REG_IO_DATA     4'hc
// CTRL fields
`define CTRL_FETCH_DONE 0
`define CTRL_INDEXED    1
`define CTRL_SHORT_OP   2
`define CTRL_ILLEGAL    3
`define CTRL_PRIV_ROM   4
`define CTRL_PSW7       5
`define CTRL_MEM_BUSY   6
`define CTRL_ATN        7
`define CTRL_DC         8
`define CTRL_MALF       9
`define CTRL_CATN       10
`define CTRL_SNGL       11
`define CTRL_PFAIL      12
`define CTRL_FIRST_EX   13
`define CTRL_ABORT_CLR  14
`define CTRL_NO_RAL     15
`define CTRL_STATUS_REQ 16
// MICRO fields: strobe of one micro-instruction
`define MIC_DO          0
`define MIC_PHASE_EXIT  1
`define MIC_IO_IN       2
`define MIC_IO_OUT      3
`define MIC_BIT7_LCC    4
`define MIC_BIT9_CLR    5
`define MIC_BIT10_WSET  6
`define MIC_BIT11_WRST  7
`define MIC_BIT12_ALARM_REGISTER  8
`define MIC_BIT15_PDN   9
`define MIC_SEL_LO      14
`define MIC_SEL_HI      15
`define MIC_ALARM_LO    16
`define MIC_ALARM_HI    18
`define MIC_FLAGS_LO    20
`define MIC_FLAGS_HI    23
// Phase codes, one-hot
`define PH_FETCH        4'h1
`define PH_ADDR         4'h2
`define PH_EXEC         4'h4
`define PH_SERVICE      4'h8
// Micro-addresses
`define UA_ILLEGAL      8'h80
`define UA_PRIV_BIT     4
`define UA_ABORT        12'h00a
`define UA_INTERRUPT    12'h010
// Timing: figures in ns; then AXI response codes
`define CLK_NS          20
`define TIMEOUT_NS      13000
`define DATA_SETUP_NS   100
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: hdl/phase_sequencer.v
// Function
// - Indexed storage instruction goes fetch to address-calculation phase.
// - Address-phase exit DO advances to execution phase unless memory busy on a non-short op.
// - Address-routine exit read waits while memory still busy.
// - Short op-codes exit address phase in one cycle, no memory.
// - Illegal instruction enters service with forced high micro-address bits.
// - Abort enable sets entering execution, clears on state-changing operations.
// - Abort-enabled events set abort test, entering service at 00A.
// - Execution exit samples synchronized interrupt, service at 010 if set.
// - No interrupt pending returns execution phase to fetch.
// - Clear command and service entry clear flags and counters.
// - Condition code takes flags before they are cleared.
// - Bits set/reset panel wait; bit 15 sets system halt.
// - Alarm bits load condition code, ORed with flags if both.
// - I/O sequence starts on I/O load without abort.
// - Input sets line and sequence in the same cycle; clocks freeze until sync.
// - Controller answers with data and sync; no start until sync dropped.
// - Line set starts 13 us timeout making latched false sync.
// - False sync sets overflow flag and forces status bit 13.
// - Input line reset edge loads destination from result bus.
// - Output sets sequence, then line 100 ns later; sequence drops first.
// - Output sync resets sequence, then line; false sync held until.
// - Phase counter resets to service; service steps only to fetch.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`include "phase_seq_map.vh"
module phase_sequencer (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // I/O bus
  input  wire        device_sync,
  input  wire [15:0] io_data_in,
  input  wire        halfword_test_line,
  output reg  [15:0] io_data_out,
  output reg         io_data_oe,
  output reg  [3:0]  control_line,
  // Processor status
  output reg  [3:0]  phase,
  output reg         clock_freeze,
  output reg         system_halt_ff,
  output reg         panel_wait
);
  localparam integer TIMEOUT_CYC = `TIMEOUT_NS / `CLK_NS;
  localparam integer SETUP_CYC   = (`DATA_SETUP_NS + `CLK_NS - 1) / `CLK_NS;
  // Control registers
  reg  [31:0] ctrl;
  reg  [31:0] micro;
  reg         micro_stb;
  reg  [15:0] io_out_word;
  // Pin synchronisers
  reg         sync_m;
  reg         sync_s;
  reg         hw_m;
  reg         hw_s;
  reg  [15:0] din_m;
  reg  [15:0] din_s;
  // State
  reg         abort_enable_ff;
  reg         abort_test_ff;
  reg         int_test_ff;
  reg  [3:0]  flag_register;
  reg  [3:0]  cond_code;
  reg         bank_ff;
  reg         utility_ff;
  reg         mode_c_ff;
  reg         repeat_ff;
  reg  [7:0]  iter_counter;
  reg  [11:0] micro_addr;
  reg         io_sequence_ff;
  reg         line_ff;
  reg         false_sync_latch;
  reg         io_input;
  reg         io_status;
  reg  [15:0] dest_reg;
  reg         b13_forced;
  reg  [9:0]  timeout_cnt;
  reg  [2:0]  setup_cnt;
  reg         do_wait;
  // AXI state
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  wire        is_do    = micro_stb & micro[`MIC_DO];
  wire        exits    = is_do & micro[`MIC_PHASE_EXIT];
  wire        mem_busy = ctrl[`CTRL_MEM_BUSY];
  wire        any_sync = sync_s | false_sync_latch;
  wire        abort_now = abort_test_ff & (phase == `PH_EXEC) & ~ctrl[`CTRL_NO_RAL];
  wire        int_a = (ctrl[`CTRL_ATN] | ctrl[`CTRL_DC] | ctrl[`CTRL_MALF]);
  wire        int_b = ctrl[`CTRL_CATN] | ctrl[`CTRL_SNGL] | ctrl[`CTRL_PFAIL];
  wire        to_service;
  reg  [3:0]  next_phase;

  // Phase transitions
  always @* begin
    next_phase = phase;
    case (phase)
      `PH_SERVICE: begin
        if (exits)
          next_phase = `PH_FETCH;
      end
      `PH_FETCH: begin
        if (ctrl[`CTRL_FETCH_DONE] & micro_stb)
          next_phase = ctrl[`CTRL_INDEXED] ? `PH_ADDR : `PH_EXEC;
      end
      `PH_ADDR: begin
        if (exits & (ctrl[`CTRL_SHORT_OP] | ~mem_busy))
          next_phase = `PH_EXEC;
      end
      `PH_EXEC: begin
        if (micro_stb & ctrl[`CTRL_ILLEGAL])
          next_phase = `PH_SERVICE;
        else if (abort_now)
          next_phase = `PH_SERVICE;
        else if (exits)
          next_phase = int_test_ff ? `PH_SERVICE : `PH_FETCH;
      end
      default: next_phase = `PH_SERVICE;
    endcase
  end
  assign to_service = (next_phase == `PH_SERVICE) & (phase != `PH_SERVICE);

  always @(posedge clk) begin
    sync_m <= device_sync;
    sync_s <= sync_m;
    hw_m   <= halfword_test_line;
    hw_s   <= hw_m;
    din_m  <= io_data_in;
    din_s  <= din_m;
  end

  // Core state
  always @(posedge clk) begin
    if (rst) begin
      phase           <= `PH_SERVICE;
      abort_enable_ff <= 1'b0;
      abort_test_ff   <= 1'b0;
      int_test_ff     <= 1'b0;
      flag_register   <= 4'h0;
      cond_code       <= 4'h0;
      bank_ff         <= 1'b0;
      utility_ff      <= 1'b0;
      mode_c_ff       <= 1'b0;
      repeat_ff       <= 1'b0;
      iter_counter    <= 8'h00;
      micro_addr      <= 12'h000;
      panel_wait      <= 1'b0;
      system_halt_ff  <= 1'b0;
      do_wait         <= 1'b0;
    end else begin
      phase         <= next_phase;
      int_test_ff   <= int_a | int_b;
      do_wait       <= (phase == `PH_ADDR) & exits & mem_busy & ~ctrl[`CTRL_SHORT_OP];
      if (micro_stb & ~is_do)
        iter_counter <= iter_counter + 8'h01;
      if ((phase != `PH_EXEC) & (next_phase == `PH_EXEC))
        abort_enable_ff <= 1'b1;
      if (ctrl[`CTRL_ABORT_CLR] & micro_stb & (phase == `PH_EXEC))
        abort_enable_ff <= 1'b0;
      if (abort_enable_ff & int_a)
        abort_test_ff <= 1'b1;
      else if (phase != `PH_EXEC)
        abort_test_ff <= 1'b0;
      if (to_service & micro_stb & ctrl[`CTRL_ILLEGAL]) begin
        micro_addr <= 12'h000;
        micro_addr[`UA_PRIV_BIT + 4] <= 1'b0;
        micro_addr[11:4] <= `UA_ILLEGAL
          | ((ctrl[`CTRL_PRIV_ROM] & ctrl[`CTRL_PSW7]) ? 8'h10 : 8'h00);
      end else if (to_service & abort_now)
        micro_addr <= `UA_ABORT;
      else if (to_service)
        micro_addr <= `UA_INTERRUPT;
      if (micro_stb & ~is_do)
        flag_register[2:0] <= micro[`MIC_FLAGS_LO +: 3];
      if (is_do) begin
        if (micro[`MIC_BIT7_LCC] & micro[`MIC_BIT12_ALARM_REGISTER])
          cond_code <= {1'b0, micro[`MIC_ALARM_HI:`MIC_ALARM_LO]} | flag_register;
        else if (micro[`MIC_BIT7_LCC])
          cond_code <= flag_register;
        else if (micro[`MIC_BIT12_ALARM_REGISTER])
          cond_code[2:0] <= micro[`MIC_ALARM_HI:`MIC_ALARM_LO];
        if (micro[`MIC_BIT10_WSET])
          panel_wait <= 1'b1;
        else if (micro[`MIC_BIT11_WRST])
          panel_wait <= 1'b0;
        if (micro[`MIC_BIT15_PDN])
          system_halt_ff <= 1'b1;
      end
      if ((is_do & micro[`MIC_BIT9_CLR]) | to_service) begin
        bank_ff       <= 1'b0;
        utility_ff    <= 1'b0;
        mode_c_ff     <= 1'b0;
        repeat_ff     <= 1'b0;
        flag_register <= 4'h0;
        iter_counter  <= 8'h00;
      end
      // overflow set wins
      // After the clear so a coinciding false sync is never lost
      if (false_sync_latch)
        flag_register[3] <= 1'b1;
    end
  end

  // I/O sequencer
  always @(posedge clk) begin
    if (rst) begin
      io_sequence_ff   <= 1'b0;
      line_ff          <= 1'b0;
      false_sync_latch <= 1'b0;
      io_input         <= 1'b0;
      io_status        <= 1'b0;
      dest_reg         <= 16'h0000;
      b13_forced       <= 1'b0;
      timeout_cnt      <= 10'h000;
      setup_cnt        <= 3'h0;
      control_line     <= 4'h0;
      io_data_out      <= 16'h0000;
      io_data_oe       <= 1'b0;
      clock_freeze     <= 1'b0;
    end else begin
      if (~io_sequence_ff & ~line_ff & ~sync_s & micro_stb & ~abort_now
          & (micro[`MIC_IO_IN] | micro[`MIC_IO_OUT])) begin
        io_input     <= micro[`MIC_IO_IN];
        io_status    <= ctrl[`CTRL_STATUS_REQ];
        b13_forced   <= 1'b0;
        io_sequence_ff <= 1'b1;
        clock_freeze <= 1'b1;
        setup_cnt    <= 3'h0;
        line_ff      <= micro[`MIC_IO_IN];
        io_data_out  <= io_out_word;
        io_data_oe   <= micro[`MIC_IO_OUT];
        control_line <= micro[`MIC_IO_IN] ?
          (4'h1 << micro[`MIC_SEL_HI:`MIC_SEL_LO]) : 4'h0;
      end
      if (io_sequence_ff & ~io_input & ~line_ff & ~any_sync) begin
        setup_cnt <= setup_cnt + 3'h1;
        if (setup_cnt == SETUP_CYC[2:0] - 3'h1) begin
          line_ff      <= 1'b1;
          control_line <= 4'h1 << micro[`MIC_SEL_HI:`MIC_SEL_LO];
        end
      end
      if (line_ff & ~sync_s & ~false_sync_latch) begin
        timeout_cnt <= timeout_cnt + 10'h001;
        if (timeout_cnt == TIMEOUT_CYC[9:0] - 10'h001)
          false_sync_latch <= 1'b1;
      end
      if (io_sequence_ff & line_ff & any_sync) begin
        io_sequence_ff <= 1'b0;
        if (~io_input)
          control_line <= 4'h0;
      end
      if (~io_sequence_ff & line_ff) begin
        line_ff          <= 1'b0;
        control_line     <= 4'h0;
        false_sync_latch <= 1'b0;
        timeout_cnt      <= 10'h000;
        clock_freeze     <= 1'b0;
        io_data_oe       <= 1'b0;
        if (io_input) begin
          dest_reg   <= din_s;
          b13_forced <= false_sync_latch & io_status;
          if (false_sync_latch & io_status)
            dest_reg[2] <= 1'b1;
        end
      end
    end
  end

  // AXI4-Lite slave
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      ctrl          <= 32'h00000000;
      micro         <= 32'h00000000;
      micro_stb     <= 1'b0;
      io_out_word   <= 16'h0000;
    end else begin
      micro_stb     <= 1'b0;
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (aw_held & w_held & ~s_axi_bvalid & ~clock_freeze & ~do_wait) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr)
          `REG_CTRL: ctrl <= w_data;
          `REG_MICRO: begin
            micro     <= w_data;
            micro_stb <= 1'b1;
          end
          `REG_IO_DATA: io_out_word <= w_data[15:0];
          `REG_STATUS: s_axi_bresp <= `RESP_SLVERR;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL:    s_axi_rdata <= ctrl;
          `REG_MICRO:   s_axi_rdata <= micro;
          `REG_STATUS:  s_axi_rdata <= {micro_addr, hw_s, b13_forced, false_sync_latch,
                                        line_ff, io_sequence_ff, abort_test_ff,
                                        abort_enable_ff, system_halt_ff, cond_code,
                                        flag_register, phase};
          `REG_IO_DATA: s_axi_rdata <= {16'h0000, dest_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: tb/phase_seq_checker.sv
`include "phase_seq_map.vh"
module phase_seq_checker (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Watched ports
  input wire       device_sync,
  input wire [3:0] control_line,
  input wire       io_data_oe,
  input wire [3:0] phase,
  input wire       clock_freeze
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  int line_cycles;

  // Counts how long a control line has stood
  always @(posedge clk) begin
    if (rst || control_line == 4'h0)
      line_cycles <= 0;
    else
      line_cycles <= line_cycles + 1;
  end

  // Ignores the first edge after reset, where the past still holds pre-reset values
  sequence left(logic [3:0] p);
    !$past(rst) && $past(phase) == p && phase != p;
  endsequence

  sequence answered;
    $rose(device_sync) && control_line != 4'h0;
  endsequence

  phase_one_hot_a: assert property ($onehot(phase))
    else $error("phase code not one-hot");
  reset_phase_a: assert property ($fell(rst) |-> phase == `PH_SERVICE)
    else $error("phase not service after reset");
  service_exit_a: assert property (left(`PH_SERVICE) |-> phase == `PH_FETCH)
    else $error("service left to a phase other than fetch");
  addr_exit_a: assert property (left(`PH_ADDR) |-> phase == `PH_EXEC)
    else $error("address phase left to a phase other than exec");
  exec_exit_a: assert property (left(`PH_EXEC) |-> phase inside {`PH_FETCH, `PH_SERVICE})
    else $error("exec phase left to a bad phase");
  line_single_a: assert property ($onehot0(control_line))
    else $error("more than one control line");
  line_frozen_a: assert property (control_line != 4'h0 |-> clock_freeze)
    else $error("control line without clock freeze");
  data_lead_a: assert property ($rose(control_line != 4'h0) && io_data_oe |->
    $past(io_data_oe, 4))
    else $error("output data too late before control line");
  data_trail_a: assert property ($fell(control_line != 4'h0) && $past(io_data_oe) |->
    io_data_oe)
    else $error("output data dropped with control line");
  sync_ends_a: assert property (answered |-> ##[1:8] control_line == 4'h0)
    else $error("control line not dropped after sync");
  timeout_bound_a: assert property (line_cycles <= 760)
    else $error("control line outlived the timeout");
  sync_blocks_a: assert property (device_sync [*4] |-> !$rose(clock_freeze))
    else $error("transfer started while sync still high");
endmodule

// File: tb/io_device_model.sv
module io_device_model (
  // Clock
  input  wire         clk,
  // Lines from the block
  input  wire  [3:0]  control_line,
  input  wire  [15:0] io_data_out,
  // Scenario controls
  input  wire         silent,
  input  wire  [7:0]  lag,
  input  wire  [15:0] reply,
  // Lines to the block, plus seen_line and taken read back by the bench
  output logic        device_sync,
  output logic [15:0] io_data_in,
  output logic        halfword_test_line,
  output logic [3:0]  seen_line,
  output logic [15:0] taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_cnt = 8'h0;

  initial begin
    device_sync = 1'b0;
    io_data_in = 16'h5a5a;
    seen_line = 4'h0;
    taken = 16'h0;
  end

  assign halfword_test_line = control_line != 4'h0 && !silent;

  always @(posedge clk) begin
    if (control_line != 4'h0 && !silent) begin
      seen_line <= control_line;
      if (wait_cnt < lag)
        wait_cnt <= wait_cnt + 8'h1;
      else if (!device_sync) begin
        io_data_in <= reply;
        taken <= io_data_out;
        device_sync <= 1'b1;
      end
    end else begin
      wait_cnt <= 8'h0;
      // sync drops after line; released data no longer valid
      if (device_sync)
        io_data_in <= ~io_data_in;
      device_sync <= 1'b0;
    end
  end
endmodule

// File: tb/tb.sv
`include "phase_seq_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, silent = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        device_sync, halfword_test_line, io_data_oe, clock_freeze;
  logic        system_halt_ff, panel_wait;
  logic [15:0] io_data_in, io_data_out, taken, reply = 16'h0;
  logic [3:0]  control_line, phase, seen_line;
  logic [7:0]  lag = 8'h3;
  int          fail_count = 0, compares = 0, n;

  always #10 clk = ~clk;

  phase_sequencer u_phase_sequencer (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .device_sync(device_sync), .io_data_in(io_data_in),
    .halfword_test_line(halfword_test_line), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .control_line(control_line), .phase(phase),
    .clock_freeze(clock_freeze), .system_halt_ff(system_halt_ff), .panel_wait(panel_wait));

  io_device_model u_io_device_model (.clk(clk), .control_line(control_line),
    .io_data_out(io_data_out), .silent(silent), .lag(lag), .reply(reply),
    .device_sync(device_sync), .io_data_in(io_data_in),
    .halfword_test_line(halfword_test_line), .seen_line(seen_line), .taken(taken));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // Every step strobes a micro word; fetch completion needs one too
  task automatic step(input logic [31:0] ctrl, input logic [31:0] micro, input logic [3:0] exp);
    int k;
    axw(`REG_CTRL, ctrl);
    axw(`REG_MICRO, micro);
    k = 0;
    @(posedge clk);
    while (phase !== exp && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(phase, exp, "phase");
  endtask

  // Strobes an I/O load and waits out the frozen span
  task automatic io_run(input logic [31:0] micro);
    axw(`REG_MICRO, micro);
    n = 0;
    while (clock_freeze !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    while (clock_freeze === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic t_input;
    reply <= 16'hc35a;
    io_run(32'h0000_8004);
    chk(seen_line, 4'h4, "input line");
    axr(`REG_IO_DATA);
    chk(rd[15:0], 16'hc35a, "input word");
  endtask

  task automatic t_output;
    lag <= 8'd12;
    axw(`REG_IO_DATA, 32'h0000_a5c3);
    io_run(32'h0000_4008);
    chk(taken, 16'ha5c3, "output word");
    chk(seen_line, 4'h2, "output line");
    lag <= 8'h3;
  endtask

  task automatic t_timeout;
    axw(`REG_CTRL, 32'h1 << `CTRL_STATUS_REQ);
    silent <= 1'b1;
    io_run(32'h0000_0004);
    chk(n >= 650 && n <= 770, 1, "timeout span");
    chk(control_line, 4'h0, "line after timeout");
    axr(`REG_IO_DATA);
    chk(rd[2], 1'b1, "status forced bit");
    axr(`REG_STATUS);
    chk(rd[7], 1'b1, "overflow flag");
    silent <= 1'b0;
    axw(`REG_CTRL, 32'h0);
  endtask

  task automatic t_phases;
    step(32'h0, 32'h3, `PH_FETCH);
    step(32'h3, 32'h0, `PH_ADDR);
    step(32'h1 << `CTRL_MEM_BUSY, 32'h3, `PH_ADDR);
    step(32'h0, 32'h3, `PH_EXEC);
    step(32'h0, 32'h3, `PH_FETCH);
    step(32'h3, 32'h0, `PH_ADDR);
    step(32'h44, 32'h3, `PH_EXEC);
    step(32'h0, 32'h3, `PH_FETCH);
  endtask

  task automatic t_interrupt;
    step(32'h3, 32'h0, `PH_ADDR);
    step(32'h0, 32'h3, `PH_EXEC);
    step(32'h1 << `CTRL_CATN, 32'h3, `PH_SERVICE);
    axr(`REG_STATUS);
    chk(rd[31:20], 12'h010, "interrupt entry");
    chk(rd[7:4], 4'h0, "flags cleared on service");
    axw(`REG_STATUS, 32'h0);
    chk(resp, `RESP_SLVERR, "status write response");
  endtask

  task automatic t_illegal;
    step(32'h0, 32'h3, `PH_FETCH);
    step(32'h1, 32'h0, `PH_EXEC);
    step(32'h1 << `CTRL_ILLEGAL, 32'h1, `PH_SERVICE);
    axr(`REG_STATUS);
    chk(rd[31:20], 12'h800, "illegal entry");
  endtask

  task automatic t_abort;
    step(32'h0, 32'h3, `PH_FETCH);
    step(32'h1, 32'h0, `PH_EXEC);
    axr(`REG_STATUS);
    chk(rd[13], 1'b1, "abort enable");
    step(32'h1 << `CTRL_ATN, 32'h0, `PH_SERVICE);
    axr(`REG_STATUS);
    chk(rd[31:20], 12'h00a, "abort entry");
    axw(`REG_CTRL, 32'h0);
  endtask

  task automatic t_wait_halt;
    axw(`REG_MICRO, 32'h41);
    @(posedge clk);
    chk(panel_wait, 1'b1, "wait set");
    axw(`REG_MICRO, 32'h81);
    @(posedge clk);
    chk(panel_wait, 1'b0, "wait reset");
    axw(`REG_MICRO, 32'h50101);
    axr(`REG_STATUS);
    chk(rd[11:8], 4'h5, "alarm into condition code");
    axw(`REG_MICRO, 32'h201);
    repeat (2) @(posedge clk);
    chk(system_halt_ff, 1'b1, "halt");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(phase, `PH_SERVICE, "reset phase");
    t_input();
    t_output();
    t_timeout();
    t_phases();
    t_interrupt();
    t_illegal();
    t_abort();
    t_wait_halt();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end
endmodule

bind phase_sequencer phase_seq_checker u_phase_seq_checker (.clk(clk), .rst(rst),
  .device_sync(device_sync), .control_line(control_line), .io_data_oe(io_data_oe),
  .phase(phase), .clock_freeze(clock_freeze));
